// *** pin_mux_pkg.sv ***
package pin_mux_pkg;

    // pin function selection, taken from the low bits of the control word
    typedef enum logic [1:0] {
        MODE_GPIO,
        MODE_PCI,
        MODE_NONPCI,
        MODE_OFF
    } pin_mode_t;

    // control word layout
    localparam int CTRL_WIDTH = 24;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_WIDTH = 2;
    localparam int CTRL_TA_POL_BIT = 2;
    localparam logic [23:0] CTRL_RESET = 24'h00_0000;

    // gpio lines 20..23 occupy bits 20..23 of the direction word
    localparam int DIR_WIDTH = 24;
    localparam int GPIO_LSB = 20;
    localparam int GPIO_COUNT = 4;
    localparam logic [23:0] DIR_RESET = 24'h00_0000;

    // pin slots inside the shared pin vectors
    localparam int PIN_COUNT = 4;
    localparam int PIN_TRDY = 0;
    localparam int PIN_IRDY = 1;
    localparam int PIN_DEVSEL = 2;
    localparam int PIN_LOCK = 3;

endpackage

// *** pin_mux_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// per-pin drive requests from the host core toward the mux
interface pin_mux_if;
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] in;
    modport core
    (
        output out,
        output oe,
        input in
    );
    modport mux
    (
        input out,
        input oe,
        output in
    );
endinterface

`default_nettype wire

// *** gpio_slice.sv ***
`timescale 1ns/1ps
`default_nettype none

// gpio lines 20..23, each with its own direction bit
module gpio_slice
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // control
    input wire logic enable_i,
    input wire logic [3:0] dir_i,
    input wire logic [3:0] data_out_i,
    // pin side
    pin_mux_if.core pins,
    // captured input value
    output logic [3:0] data_in_o
);

    // drive only in gpio mode, per-bit direction
    assign pins.out = data_out_i;
    assign pins.oe = enable_i ? dir_i : 4'h0;

    // capture pins configured as inputs
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            data_in_o <= 4'h0;
        else if (enable_i)
            data_in_o <= pins.in & ~dir_i;
    end

endmodule

`default_nettype wire

// *** host_port_pin_function_mux.sv ***
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - pci mode: target ready, initiator ready, device select pins are two-way
// - pci mode: lock and grant are sampled inputs, request driven out
// - pci mode: parity and parity error pins are two-way
// - non-pci mode: data bus enable and direction driven on ready pins
// - non-pci mode: select acknowledge on device select, lock pin is bus strobe
// - non-pci mode: parity pin is dma acknowledge in, parity error is dma request
// - non-pci mode: request pin is transfer acknowledge with selectable polarity
// - gpio mode: lines 20 to 23 each follow their direction bit
// - gpio mode: parity, parity error, grant, request pins are disconnected
// - pin function follows the 24-bit control register
module host_port_pin_function_mux
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // configuration words
    input wire logic [23:0] port_control_register_i,
    input wire logic [23:0] port_direction_register_i,
    // pci side of the core
    input wire logic pci_trdy_out_i,
    input wire logic pci_trdy_oe_i,
    input wire logic pci_irdy_out_i,
    input wire logic pci_irdy_oe_i,
    input wire logic pci_devsel_out_i,
    input wire logic pci_devsel_oe_i,
    input wire logic pci_par_out_i,
    input wire logic pci_par_oe_i,
    input wire logic pci_perr_out_i,
    input wire logic pci_perr_oe_i,
    input wire logic pci_req_i,
    output logic pci_trdy_o,
    output logic pci_irdy_o,
    output logic pci_devsel_o,
    output logic pci_lock_o,
    output logic pci_par_o,
    output logic pci_perr_o,
    output logic pci_grant_o,
    // non-pci side of the core
    input wire logic data_bus_enable_i,
    input wire logic data_bus_direction_i,
    input wire logic select_acknowledge_i,
    input wire logic dma_request_i,
    input wire logic transfer_acknowledge_i,
    output logic bus_strobe_o,
    output logic dma_acknowledge_o,
    // gpio data
    input wire logic [3:0] gpio_data_i,
    output logic [3:0] gpio_data_o,
    // mode status
    output logic [1:0] mode_o,
    // target ready / data bus enable / gpio 20
    input wire logic pci_target_ready_pin_i,
    output logic pci_target_ready_pin_o,
    output logic pci_target_ready_pin_oe_o,
    // initiator ready / data bus direction / gpio 21
    input wire logic pci_initiator_ready_pin_i,
    output logic pci_initiator_ready_pin_o,
    output logic pci_initiator_ready_pin_oe_o,
    // device select / select acknowledge / gpio 22
    input wire logic pci_device_select_pin_i,
    output logic pci_device_select_pin_o,
    output logic pci_device_select_pin_oe_o,
    // lock / bus strobe / gpio 23
    input wire logic pci_lock_in_i,
    output logic pci_lock_in_o,
    output logic pci_lock_in_oe_o,
    // parity / dma acknowledge
    input wire logic pci_parity_pin_i,
    output logic pci_parity_pin_o,
    output logic pci_parity_pin_oe_o,
    // parity error / dma request
    input wire logic pci_parity_error_pin_i,
    output logic pci_parity_error_pin_o,
    output logic pci_parity_error_pin_oe_o,
    // grant, sampled in pci mode only
    input wire logic pci_grant_in_i,
    // request / transfer acknowledge
    output logic pci_request_out_o,
    output logic pci_request_out_oe_o
);

    // mode decode from the control word
    wire logic [1:0] mode_bits;
    wire logic is_pci;
    wire logic is_nonpci;
    wire logic is_gpio;
    wire logic ta_active_high;
    assign mode_bits = port_control_register_i[pin_mux_pkg::CTRL_MODE_LSB +: 2];
    assign is_pci = mode_bits == pin_mux_pkg::MODE_PCI;
    assign is_nonpci = mode_bits == pin_mux_pkg::MODE_NONPCI;
    assign is_gpio = mode_bits == pin_mux_pkg::MODE_GPIO;
    assign ta_active_high = port_control_register_i[pin_mux_pkg::CTRL_TA_POL_BIT];

    // gpio slice on the four shared pins
    pin_mux_if gp ();
    wire logic [3:0] gp_in_q;
    wire logic [3:0] pin_in;
    assign pin_in = {pci_lock_in_i, pci_device_select_pin_i,
                     pci_initiator_ready_pin_i, pci_target_ready_pin_i};
    assign gp.in = pin_in;

    gpio_slice u_gpio
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .enable_i(is_gpio),
        .dir_i(port_direction_register_i[pin_mux_pkg::GPIO_LSB +: 4]),
        .data_out_i(gpio_data_i),
        .pins(gp.core),
        .data_in_o(gp_in_q)
    );

    // transfer acknowledge level after polarity
    wire logic ta_level;
    assign ta_level = ta_active_high ? transfer_acknowledge_i : ~transfer_acknowledge_i;

    // next pin drive values per mode
    logic [3:0] sh_out_d;
    logic [3:0] sh_oe_d;
    logic par_d;
    logic par_oe_d;
    logic perr_d;
    logic perr_oe_d;
    logic req_d;
    logic req_oe_d;
    always_comb
    begin
        sh_out_d = 4'h0;
        sh_oe_d = 4'h0;
        par_d = 1'b0;
        par_oe_d = 1'b0;
        perr_d = 1'b0;
        perr_oe_d = 1'b0;
        req_d = 1'b0;
        req_oe_d = 1'b0;
        if (is_pci)
        begin
            sh_out_d = {1'b0, pci_devsel_out_i, pci_irdy_out_i, pci_trdy_out_i};
            sh_oe_d = {1'b0, pci_devsel_oe_i, pci_irdy_oe_i, pci_trdy_oe_i};
            par_d = pci_par_out_i;
            par_oe_d = pci_par_oe_i;
            perr_d = pci_perr_out_i;
            perr_oe_d = pci_perr_oe_i;
            req_d = pci_req_i;
            req_oe_d = 1'b1;
        end
        else if (is_nonpci)
        begin
            sh_out_d = {1'b0, select_acknowledge_i, data_bus_direction_i,
                        data_bus_enable_i};
            sh_oe_d = 4'h7;
            perr_d = dma_request_i;
            perr_oe_d = 1'b1;
            req_d = ta_level;
            req_oe_d = 1'b1;
        end
        else if (is_gpio)
        begin
            sh_out_d = gp.out;
            sh_oe_d = gp.oe;
        end
        // gpio: parity, parity error and request stay undriven
    end

    // registered pin drive
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            {pci_lock_in_o, pci_device_select_pin_o,
             pci_initiator_ready_pin_o, pci_target_ready_pin_o} <= 4'h0;
            {pci_lock_in_oe_o, pci_device_select_pin_oe_o,
             pci_initiator_ready_pin_oe_o, pci_target_ready_pin_oe_o} <= 4'h0;
            pci_parity_pin_o <= 1'b0;
            pci_parity_pin_oe_o <= 1'b0;
            pci_parity_error_pin_o <= 1'b0;
            pci_parity_error_pin_oe_o <= 1'b0;
            pci_request_out_o <= 1'b0;
            pci_request_out_oe_o <= 1'b0;
        end
        else
        begin
            {pci_lock_in_o, pci_device_select_pin_o,
             pci_initiator_ready_pin_o, pci_target_ready_pin_o} <= sh_out_d;
            {pci_lock_in_oe_o, pci_device_select_pin_oe_o,
             pci_initiator_ready_pin_oe_o, pci_target_ready_pin_oe_o} <= sh_oe_d;
            pci_parity_pin_o <= par_d;
            pci_parity_pin_oe_o <= par_oe_d;
            pci_parity_error_pin_o <= perr_d;
            pci_parity_error_pin_oe_o <= perr_oe_d;
            pci_request_out_o <= req_d;
            pci_request_out_oe_o <= req_oe_d;
        end
    end

    // registered inward values, gated by mode
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pci_trdy_o <= 1'b0;
            pci_irdy_o <= 1'b0;
            pci_devsel_o <= 1'b0;
            pci_lock_o <= 1'b0;
            pci_par_o <= 1'b0;
            pci_perr_o <= 1'b0;
            pci_grant_o <= 1'b0;
            bus_strobe_o <= 1'b0;
            dma_acknowledge_o <= 1'b0;
            gpio_data_o <= 4'h0;
            mode_o <= 2'h0;
        end
        else
        begin
            pci_trdy_o <= is_pci & pci_target_ready_pin_i;
            pci_irdy_o <= is_pci & pci_initiator_ready_pin_i;
            pci_devsel_o <= is_pci & pci_device_select_pin_i;
            pci_lock_o <= is_pci & pci_lock_in_i;
            pci_grant_o <= is_pci & pci_grant_in_i;
            pci_par_o <= is_pci & pci_parity_pin_i;
            pci_perr_o <= is_pci & pci_parity_error_pin_i;
            bus_strobe_o <= is_nonpci & pci_lock_in_i;
            dma_acknowledge_o <= is_nonpci & pci_parity_pin_i;
            gpio_data_o <= gp_in_q;
            mode_o <= mode_bits;
        end
    end

endmodule

`default_nettype wire

// *** host_port_pin_function_mux_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_function_mux_monitor
(
    // clock, reset, configuration and core side
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [23:0] port_control_register_i,
    input wire logic [23:0] port_direction_register_i,
    input wire logic pci_trdy_out_i,
    input wire logic pci_trdy_oe_i,
    input wire logic pci_req_i,
    input wire logic data_bus_enable_i,
    input wire logic dma_request_i,
    input wire logic transfer_acknowledge_i,
    input wire logic bus_strobe_o,
    input wire logic pci_grant_o,
    // pins
    input wire logic pci_lock_in_i,
    input wire logic pci_target_ready_pin_o,
    input wire logic pci_target_ready_pin_oe_o,
    input wire logic pci_lock_in_oe_o,
    input wire logic pci_parity_pin_oe_o,
    input wire logic pci_parity_error_pin_o,
    input wire logic pci_request_out_o,
    input wire logic pci_request_out_oe_o
);
    // mode field, one clock domain for every check
    wire logic [1:0] mode_sel = port_control_register_i[1:0];
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    property p_pci_ready;
        mode_sel == 2'd1 && pci_trdy_oe_i |=> pci_target_ready_pin_oe_o
            && pci_target_ready_pin_o == $past(pci_trdy_out_i);
    endproperty
    a_pci_ready: assert property (p_pci_ready) else $error("pci ready pin");
    property p_pci_req;
        mode_sel == 2'd1 |=> pci_request_out_oe_o && !pci_lock_in_oe_o
            && pci_request_out_o == $past(pci_req_i);
    endproperty
    a_pci_req: assert property (p_pci_req) else $error("pci request or lock");
    property p_np_enable;
        mode_sel == 2'd2 |=> pci_target_ready_pin_oe_o
            && pci_target_ready_pin_o == $past(data_bus_enable_i);
    endproperty
    a_np_enable: assert property (p_np_enable) else $error("data bus enable");
    property p_np_strobe;
        mode_sel == 2'd2 |=> !pci_lock_in_oe_o && bus_strobe_o == $past(pci_lock_in_i);
    endproperty
    a_np_strobe: assert property (p_np_strobe) else $error("bus strobe");
    property p_np_dma;
        mode_sel == 2'd2 |=> !pci_parity_pin_oe_o && pci_parity_error_pin_o == $past(dma_request_i);
    endproperty
    a_np_dma: assert property (p_np_dma) else $error("dma pins");
    property p_np_ta;
        mode_sel == 2'd2 |=> pci_request_out_oe_o && pci_request_out_o
            == ($past(transfer_acknowledge_i) ~^ $past(port_control_register_i[2]));
    endproperty
    a_np_ta: assert property (p_np_ta) else $error("transfer acknowledge");
    property p_gpio_dir;
        mode_sel == 2'd0 |=> pci_lock_in_oe_o == $past(port_direction_register_i[23])
            && pci_target_ready_pin_oe_o == $past(port_direction_register_i[20]);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction");
    property p_gpio_cut;
        mode_sel == 2'd0 ##1 mode_sel == 2'd0 |=> !pci_parity_pin_oe_o
            && !pci_request_out_oe_o && !pci_grant_o;
    endproperty
    a_gpio_cut: assert property (p_gpio_cut) else $error("gpio cut pins");
endmodule
bind host_port_pin_function_mux host_port_pin_function_mux_monitor mon
(
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .port_control_register_i(port_control_register_i),
    .port_direction_register_i(port_direction_register_i),
    .pci_trdy_out_i(pci_trdy_out_i),
    .pci_trdy_oe_i(pci_trdy_oe_i),
    .pci_req_i(pci_req_i),
    .data_bus_enable_i(data_bus_enable_i),
    .dma_request_i(dma_request_i),
    .transfer_acknowledge_i(transfer_acknowledge_i),
    .bus_strobe_o(bus_strobe_o),
    .pci_grant_o(pci_grant_o),
    .pci_lock_in_i(pci_lock_in_i),
    .pci_target_ready_pin_o(pci_target_ready_pin_o),
    .pci_target_ready_pin_oe_o(pci_target_ready_pin_oe_o),
    .pci_lock_in_oe_o(pci_lock_in_oe_o),
    .pci_parity_pin_oe_o(pci_parity_pin_oe_o),
    .pci_parity_error_pin_o(pci_parity_error_pin_o),
    .pci_request_out_o(pci_request_out_o),
    .pci_request_out_oe_o(pci_request_out_oe_o)
);
`default_nettype wire

// *** host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
    // design side of the shared pins
    input wire logic [5:0] pin_o_i,
    input wire logic [5:0] pin_oe_i,
    // far side levels
    input wire logic [5:0] far_i,
    // resolved pin levels
    output logic [5:0] wire_o
);
    // far end drives only where the design has let go
    assign wire_o = (pin_o_i & pin_oe_i) | (far_i & ~pin_oe_i);
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // stimulus and observed values
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [23:0] ctrl = 24'h00_0000;
    logic [23:0] dir = 24'h00_0000;
    logic [15:0] c = 16'h0000;
    logic [3:0] gd = 4'h0;
    logic [6:0] far = 7'h00;
    wire logic [6:0] po, poe, pin_in;
    logic [6:0] eo, eoe;
    wire logic [5:0] w;
    logic [5:0] ew;
    logic [3:0] gq;
    logic [1:0] mode;
    logic strobe, dack;
    int n_mismatch = 0;
    int cmp_count = 0;
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    // far side and design
    host_bus_model far_end (.pin_o_i(po[5:0]), .pin_oe_i(poe[5:0]), .far_i(far[5:0]), .wire_o(w));
    host_port_pin_function_mux uut
    (
        .clk_i(clk_i), .nrst_i(nrst_i), .port_control_register_i(ctrl),
        .port_direction_register_i(dir), .pci_trdy_out_i(c[0]), .pci_trdy_oe_i(c[1]),
        .pci_irdy_out_i(c[2]), .pci_irdy_oe_i(c[3]), .pci_devsel_out_i(c[4]),
        .pci_devsel_oe_i(c[5]), .pci_par_out_i(c[6]), .pci_par_oe_i(c[7]),
        .pci_perr_out_i(c[8]), .pci_perr_oe_i(c[9]), .pci_req_i(c[10]), .pci_trdy_o(pin_in[0]),
        .pci_irdy_o(pin_in[1]), .pci_devsel_o(pin_in[2]), .pci_lock_o(pin_in[3]),
        .pci_par_o(pin_in[4]), .pci_perr_o(pin_in[5]), .pci_grant_o(pin_in[6]),
        .data_bus_enable_i(c[11]), .data_bus_direction_i(c[12]), .select_acknowledge_i(c[13]),
        .dma_request_i(c[14]), .transfer_acknowledge_i(c[15]), .bus_strobe_o(strobe),
        .dma_acknowledge_o(dack), .gpio_data_i(gd), .gpio_data_o(gq), .mode_o(mode),
        .pci_target_ready_pin_i(w[0]), .pci_target_ready_pin_o(po[0]),
        .pci_target_ready_pin_oe_o(poe[0]), .pci_initiator_ready_pin_i(w[1]),
        .pci_initiator_ready_pin_o(po[1]), .pci_initiator_ready_pin_oe_o(poe[1]),
        .pci_device_select_pin_i(w[2]), .pci_device_select_pin_o(po[2]),
        .pci_device_select_pin_oe_o(poe[2]), .pci_lock_in_i(w[3]), .pci_lock_in_o(po[3]),
        .pci_lock_in_oe_o(poe[3]), .pci_parity_pin_i(w[4]), .pci_parity_pin_o(po[4]),
        .pci_parity_pin_oe_o(poe[4]), .pci_parity_error_pin_i(w[5]),
        .pci_parity_error_pin_o(po[5]), .pci_parity_error_pin_oe_o(poe[5]),
        .pci_grant_in_i(far[6]), .pci_request_out_o(po[6]), .pci_request_out_oe_o(poe[6])
    );
    // one counted comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic tally_and_finish;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // apply one configuration, let it settle, compare enables, pin levels and inward ports; gpio data in gpio mode only
    task automatic run(input logic [23:0] ct, input logic [23:0] dr, input logic [15:0] cc,
        input logic [3:0] g, input logic [6:0] f);
        logic np;
        np = (ct[1:0] == 2'd2);
        ctrl = ct;
        dir = dr;
        c = cc;
        gd = g;
        far = f;
        repeat (3) @(posedge clk_i);
        #1;
        eoe = 7'h00;
        eo = 7'h00;
        if (ct[1:0] == 2'd1)
        begin
            eoe = {1'b1, cc[9], cc[7], 1'b0, cc[5], cc[3], cc[1]};
            eo = {cc[10], cc[8], cc[6], 1'b0, cc[4], cc[2], cc[0]};
        end
        if (np)
        begin
            eoe = 7'h67;
            eo = {cc[15] ~^ ct[2], cc[14], 2'b00, cc[13:11]};
        end
        if (ct[1:0] == 2'd0)
        begin
            eoe = {3'b000, dr[23:20]};
            eo = {3'b000, g};
        end
        ew = (eo[5:0] & eoe[5:0]) | (f[5:0] & ~eoe[5:0]);
        chk(poe, eoe);
        chk(w, ew);
        chk(po[6] & poe[6], eo[6] & eoe[6]);
        chk(pin_in, (ct[1:0] == 2'd1) ? {f[6], ew} : 7'h00);
        chk({mode, strobe, dack}, {ct[1:0], np & ew[3], np & ew[4]});
        if (ct[1:0] == 2'd0)
            chk(gq, ew[3:0] & ~dr[23:20]);
    endtask
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_i);
        #1;
        chk(poe, 7'h00);
        nrst_i = 1'b1;
        run(24'h00_0001, 24'h00_0000, 16'h06db, 4'h0, 7'h56);
        run(24'h00_0001, 24'h00_0000, 16'h0124, 4'h0, 7'h29);
        run(24'h00_0002, 24'h00_0000, 16'ha800, 4'h0, 7'h18);
        run(24'h00_0006, 24'h00_0000, 16'hd000, 4'h0, 7'h07);
        run(24'h00_0006, 24'h00_0000, 16'h2800, 4'h0, 7'h10);
        run(24'h00_0000, 24'h50_0000, 16'hffff, 4'hf, 7'h7f);
        run(24'h00_0000, 24'ha0_0000, 16'hffff, 4'h5, 7'h35);
        run(24'h00_0000, 24'h50_0000, 16'h0000, 4'ha, 7'h05);
        run(24'h00_0003, 24'hf0_0000, 16'hffff, 4'hf, 7'h7f);
        run(24'h00_0005, 24'h00_0000, 16'hffff, 4'h0, 7'h00);
        nrst_i = 1'b0;
        #2;
        chk(poe, 7'h00);
        @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        run(24'h00_0001, 24'h00_0000, 16'h06db, 4'h0, 7'h56);
        tally_and_finish();
    end
endmodule
`default_nettype wire
